// >>> src/dual_clock_fwft_fifo_ports.v
// Purpose: Two-port FWFT FIFO with mailboxes and programmable flags
// Assumes: Port clocks are pins sampled on core_clk, well below 5 MHz
// Notes: Port A writes, port B reads; flags follow port clock edges
//
// What this block does
// - Drive port A data only while select and direction are both low.
// - Port A FIFO write when selected, gated, not mailbox and ready.
// - Port B direction inverted; drive B data while selected and dir high.
// - Port B FIFO read when selected, gated, not mailbox, output ready.
// - Selects only qualify transfers; a low gate starts nothing.
// - When output empty, next word loads automatically with ready rising.
// - Mode pins caught at reset release: serial, 64, 8 or parallel.
// - Keep X for almost-empty and Y for almost-full offsets.
// - Input-ready and almost flags pass two stages, output-ready three, in their own port clock domain.
// - Output-ready low keeps the old word and ignores reads.
// - Read pointer steps only when a new word enters output register.
// - Written word reaches output on third port B edge.
// - A port B edge coincident with a write is not its first.
// - Input-ready low means full or setup not finished; writes are then ignored.
// - Write pointer steps on each stored word.
// - Second port A edge after a freeing read raises input-ready.
// - A port A edge coincident with a read is not its first.
// - Almost-empty low at X or fewer memory words.
// - Almost-empty rises on second port B edge after the filling write.
// - Port A mailbox: write mail one, or read mail two.
// - Port B mailbox: write mail two, or read mail one.
// - Reset clears pointers and forces the documented flag levels.
// - Parallel mode: first two writes load Y then X.
// - Serial mode: shift 18 bits, Y msb first, then raise ready.
// - Almost-full low at depth minus Y or more words.
`timescale 1ns/1ps
`include "fifo_consts.vh"
module dual_clock_fwft_fifo_ports (
   input wire core_clk,
   input wire rst,
   input wire port_a_clk,
   input wire port_a_select_n,
   input wire port_a_dir_sel,
   input wire port_a_transfer_gate,
   input wire port_a_mail_sel,
   input wire [35:0] port_a_din,
   output reg [35:0] port_a_dout,
   output reg port_a_oe_n,
   input wire port_b_clk,
   input wire port_b_select_n,
   input wire port_b_dir_sel,
   input wire port_b_transfer_gate,
   input wire port_b_mail_sel,
   input wire [35:0] port_b_din,
   output reg [35:0] port_b_dout,
   output reg port_b_oe_n,
   input wire offset_mode_sel_hi,
   input wire offset_mode_sel_lo,
   input wire offset_serial_din,
   input wire offset_serial_load_n,
   output reg input_ready,
   output reg output_ready,
   output reg almost_empty_n,
   output reg almost_full_n,
   output reg mail_one_flag_n,
   output reg mail_two_flag_n
);
   // Setup state machine, one-hot
   localparam [5:0] ST_HOLD = 6'h01;
   localparam [5:0] ST_SERIAL = 6'h02;
   localparam [5:0] ST_WAIT = 6'h04;
   localparam [5:0] ST_PAR_Y = 6'h08;
   localparam [5:0] ST_PAR_X = 6'h10;
   localparam [5:0] ST_RUN = 6'h20;

   // Transfer decode shared by all six port operations
   function port_op;
      input rise;
      input sel_n;
      input gate;
      input mail;
      input want_mail;
      input dir;
      input want_dir;
      begin
         port_op = rise & ~sel_n & gate & (mail == want_mail) &
            (dir == want_dir);
      end
   endfunction

   // ==========================================================
   // Pin synchronizers
   wire [`SYNC_W-1:0] sync_out;
   wire a_clk_s;
   wire a_sel_n;
   wire a_dir;
   wire a_gate;
   wire a_mail;
   wire [`DW-1:0] a_din;
   wire b_clk_s;
   wire b_sel_n;
   wire b_dir;
   wire b_gate;
   wire b_mail;
   wire [`DW-1:0] b_din;
   wire fs_hi;
   wire fs_lo;
   wire ser_din;
   wire ser_load_n;

   pin_sync #(.WIDTH(`SYNC_W)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pins({port_a_clk, port_a_select_n, port_a_dir_sel,
             port_a_transfer_gate, port_a_mail_sel, port_a_din,
             port_b_clk, port_b_select_n, port_b_dir_sel,
             port_b_transfer_gate, port_b_mail_sel, port_b_din,
             offset_mode_sel_hi, offset_mode_sel_lo,
             offset_serial_din, offset_serial_load_n}),
      .synced(sync_out)
   );

   assign {a_clk_s, a_sel_n, a_dir, a_gate, a_mail, a_din,
           b_clk_s, b_sel_n, b_dir, b_gate, b_mail, b_din,
           fs_hi, fs_lo, ser_din, ser_load_n} = sync_out;

   // ==========================================================
   // Port clock edge pulses
   reg a_clk_q;
   reg b_clk_q;
   wire a_rise;
   wire b_rise;

   always @(posedge core_clk) begin
      if (rst) begin
         a_clk_q <= a_clk_s;
         b_clk_q <= b_clk_s;
      end else begin
         a_clk_q <= a_clk_s;
         b_clk_q <= b_clk_s;
      end
   end

   assign a_rise = a_clk_s & ~a_clk_q;
   assign b_rise = b_clk_s & ~b_clk_q;

   // ==========================================================
   // Port operation decode
   wire a_fifo_wr_sel;
   wire a_mail_wr;
   wire a_mail_rd;
   wire b_fifo_rd_sel;
   wire b_mail_wr;
   wire b_mail_rd;
   wire a_accept;

   // Transfers need the gate high on an edge
   assign a_fifo_wr_sel = port_op(a_rise, a_sel_n, a_gate, a_mail, 1'b0,
      a_dir, 1'b1);
   assign a_mail_wr = port_op(a_rise, a_sel_n, a_gate, a_mail, 1'b1,
      a_dir, 1'b1);
   assign a_mail_rd = port_op(a_rise, a_sel_n, a_gate, a_mail, 1'b1,
      a_dir, 1'b0);
   assign b_fifo_rd_sel = port_op(b_rise, b_sel_n, b_gate, b_mail, 1'b0,
      b_dir, 1'b1);
   assign b_mail_wr = port_op(b_rise, b_sel_n, b_gate, b_mail, 1'b1,
      b_dir, 1'b0);
   assign b_mail_rd = port_op(b_rise, b_sel_n, b_gate, b_mail, 1'b1,
      b_dir, 1'b1);
   assign a_accept = a_fifo_wr_sel & input_ready;

   // ==========================================================
   // Offset registers and setup sequencing
   reg [5:0] state;
   reg [3:0] mode;
   reg [1:0] edge_cnt;
   reg [4:0] ser_cnt;
   reg [`OFS_W-1:0] off_x;
   reg [`OFS_W-1:0] off_y;
   wire store_word;

   assign store_word = a_accept & (state == ST_RUN);

   // Mode caught after release, then offsets loaded
   always @(posedge core_clk) begin
      if (rst) begin
         state <= ST_HOLD;
         mode <= `MODE_PAR;
         edge_cnt <= 2'h0;
         ser_cnt <= 5'h00;
         off_x <= {`OFS_W{1'b0}};
         off_y <= {`OFS_W{1'b0}};
      end else begin
         case (state)
            ST_HOLD: begin
               edge_cnt <= 2'h0;
               ser_cnt <= 5'h00;
               state <= ST_WAIT;
               case ({fs_hi, fs_lo})
                  2'b11: begin
                     mode <= `MODE_SERIAL;
                     state <= ST_SERIAL;
                  end
                  2'b10: begin
                     mode <= `MODE_P64;
                     off_x <= `PRESET_HI;
                     off_y <= `PRESET_HI;
                  end
                  2'b01: begin
                     mode <= `MODE_P8;
                     off_x <= `PRESET_LO;
                     off_y <= `PRESET_LO;
                  end
                  default: begin
                     mode <= `MODE_PAR;
                  end
               endcase
            end
            ST_SERIAL: begin
               if (a_rise & ~ser_load_n) begin
                  {off_y, off_x} <= {off_y[`OFS_W-2:0], off_x, ser_din};
                  ser_cnt <= ser_cnt + 5'h01;
                  if (ser_cnt == `SER_LAST) begin
                     // One more edge after the last bit raises ready
                     state <= ST_RUN;
                  end
               end
            end
            ST_WAIT: begin
               if (a_rise) begin
                  if (edge_cnt == `IR_WAIT_EDGES - 2'h2) begin
                     state <= (mode == `MODE_PAR) ? ST_PAR_Y : ST_RUN;
                  end
                  edge_cnt <= edge_cnt + 2'h1;
               end
            end
            ST_PAR_Y: begin
               if (a_accept) begin
                  off_y <= a_din[`OFS_W-1:0];
                  state <= ST_PAR_X;
               end
            end
            ST_PAR_X: begin
               if (a_accept) begin
                  off_x <= a_din[`OFS_W-1:0];
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               state <= ST_RUN;
            end
            default: begin
               state <= ST_HOLD;
            end
         endcase
      end
   end

   // ==========================================================
   // Memory and write side
   reg [`DW-1:0] mem [0:`DEPTH-1];
   reg [`PW-1:0] wptr;
   reg [`PW-1:0] rptr;
   reg [`PW-1:0] fptr;
   reg [`PW-1:0] rp_a1;
   reg [`PW-1:0] wp_b1;
   reg [`PW-1:0] wp_b2;
   wire [`PW-1:0] next_wptr;
   wire [`PW-1:0] fill_a;
   wire a_ready_state;

   assign next_wptr = wptr + {{(`PW-1){1'b0}}, store_word};
   assign fill_a = next_wptr - rp_a1;
   assign a_ready_state = (state == ST_RUN) | (state == ST_PAR_Y) |
      (state == ST_PAR_X);

   // Store and step write pointer
   always @(posedge core_clk) begin
      if (store_word) begin
         mem[wptr[`AW-1:0]] <= a_din;
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         wptr <= {`PW{1'b0}};
      end else begin
         wptr <= next_wptr;
      end
   end

   // Read pointer seen by port A: one stage, then the flag flop
   always @(posedge core_clk) begin
      if (rst) begin
         rp_a1 <= {`PW{1'b0}};
         input_ready <= `RST_IR;
         almost_full_n <= `RST_AF_N;
      end else if (a_rise) begin
         rp_a1 <= rptr;
         input_ready <= a_ready_state & (fill_a != `DEPTH);
         almost_full_n <= ~(fill_a >= (`DEPTH - {1'b0, off_y}));
      end
   end

   // ==========================================================
   // Prefetch into the two-entry buffer
   wire buf_in_valid;
   wire buf_in_ready;
   wire buf_out_valid;
   wire buf_out_ready;
   wire [`DW-1:0] buf_out_data;
   wire load_out;

   // Only words already seen through two port B stages are fetched
   assign buf_in_valid = (fptr != wp_b2);

   two_entry_buffer #(.WIDTH(`DW)) u_buf (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(mem[fptr[`AW-1:0]]),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   always @(posedge core_clk) begin
      if (rst) begin
         fptr <= {`PW{1'b0}};
      end else if (buf_in_valid & buf_in_ready) begin
         fptr <= fptr + {{(`PW-1){1'b0}}, 1'b1};
      end
   end

   // ==========================================================
   // Read side and port B flags
   reg [`DW-1:0] out_reg;
   wire [`PW-1:0] next_rptr;
   wire [`PW-1:0] fill_b;

   // Auto load when empty, otherwise only on a selected read
   assign load_out = b_rise & buf_out_valid &
      (~output_ready | b_fifo_rd_sel);
   assign buf_out_ready = load_out;
   assign next_rptr = rptr + {{(`PW-1){1'b0}}, load_out};
   assign fill_b = wp_b1 - next_rptr;

   always @(posedge core_clk) begin
      if (rst) begin
         rptr <= {`PW{1'b0}};
         out_reg <= {`DW{1'b0}};
         wp_b1 <= {`PW{1'b0}};
         wp_b2 <= {`PW{1'b0}};
         output_ready <= `RST_OR;
         almost_empty_n <= `RST_AE_N;
      end else if (b_rise) begin
         wp_b1 <= wptr;
         wp_b2 <= wp_b1;
         rptr <= next_rptr;
         almost_empty_n <= (fill_b > {1'b0, off_x});
         if (load_out) begin
            out_reg <= buf_out_data;
            output_ready <= 1'b1;
         end else if (b_fifo_rd_sel) begin
            output_ready <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Mailboxes; a write to an empty box wins over a same-cycle read
   reg [`DW-1:0] mail_one;
   reg [`DW-1:0] mail_two;

   always @(posedge core_clk) begin
      if (rst) begin
         mail_one <= {`DW{1'b0}};
         mail_two <= {`DW{1'b0}};
         mail_one_flag_n <= `RST_MAIL_N;
         mail_two_flag_n <= `RST_MAIL_N;
      end else begin
         if (a_mail_wr & mail_one_flag_n) begin
            mail_one <= a_din;
            mail_one_flag_n <= 1'b0;
         end else if (b_mail_rd) begin
            mail_one_flag_n <= 1'b1;
         end
         if (b_mail_wr & mail_two_flag_n) begin
            mail_two <= b_din;
            mail_two_flag_n <= 1'b0;
         end else if (a_mail_rd) begin
            mail_two_flag_n <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Data pin drive; enables low while driving
   always @(posedge core_clk) begin
      if (rst) begin
         port_a_dout <= {`DW{1'b0}};
         port_b_dout <= {`DW{1'b0}};
         port_a_oe_n <= 1'b1;
         port_b_oe_n <= 1'b1;
      end else begin
         port_a_dout <= mail_two;
         port_a_oe_n <= ~(~a_sel_n & ~a_dir);
         port_b_dout <= b_mail ? mail_one : out_reg;
         port_b_oe_n <= ~(~b_sel_n & b_dir);
      end
   end
endmodule

// >>> src/fifo_consts.vh
// Purpose: Shared constants for the two-port FWFT FIFO block
// Assumes: Included by bare name from the design files
// Notes: Every width, count, preset and mode code lives here
`ifndef FIFO_CONSTS_VH
`define FIFO_CONSTS_VH

// ==========================================================
// Sizes
`define DW 36
`define AW 9
`define PW 10
`define DEPTH 10'h200
`define OFS_W 9
`define SER_BITS 5'h12
`define SER_LAST 5'h11

// ==========================================================
// Offset presets and mode codes (one-hot)
`define PRESET_HI 9'h040
`define PRESET_LO 9'h008
`define MODE_SERIAL 4'h1
`define MODE_P64 4'h2
`define MODE_P8 4'h4
`define MODE_PAR 4'h8

// ==========================================================
// Timing: port clock edges before input-ready rises after setup
`define IR_WAIT_EDGES 2'h2

// ==========================================================
// Flag levels held during reset
`define RST_IR 1'b0
`define RST_OR 1'b0
`define RST_AE_N 1'b0
`define RST_AF_N 1'b1
`define RST_MAIL_N 1'b1

// ==========================================================
// Synchronizer bundle width: 2 clocks, 2x(4 ctl + data), 4 offset pins
`define SYNC_W 86
`endif

// >>> src/pin_sync.v
// Purpose: Two-stage synchronizer for a bundle of pins
// Assumes: Pins are asynchronous to core_clk
// Notes: The first stage is read only by the second
`timescale 1ns/1ps
module pin_sync #(
   parameter WIDTH = 86
) (
   input wire core_clk,
   input wire rst,
   input wire [WIDTH-1:0] pins,
   output reg [WIDTH-1:0] synced
);
   reg [WIDTH-1:0] stage1;

   // ==========================================================
   // Two flops per bit, left running in reset so straps are settled
   always @(posedge core_clk) begin
      stage1 <= pins;
      synced <= stage1;
   end
endmodule

// >>> src/two_entry_buffer.v
// Purpose: Two-entry valid/ready buffer on the read data path
// Assumes: Single clock, synchronous active high reset
// Notes: Stalling the drain side fills it, then in_ready drops
`timescale 1ns/1ps
`include "fifo_consts.vh"
module two_entry_buffer #(
   parameter WIDTH = 36
) (
   input wire core_clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [1:0] count;
   reg [WIDTH-1:0] slot0;
   reg [WIDTH-1:0] slot1;
   wire push;
   wire pop;

   // ==========================================================
   // Handshake terms
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = slot0;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Slot shuffle, head always in slot0
   always @(posedge core_clk) begin
      if (rst) begin
         count <= 2'h0;
         slot0 <= {WIDTH{1'b0}};
         slot1 <= {WIDTH{1'b0}};
      end else begin
         case ({push, pop})
            2'b10: begin
               if (count == 2'h0) begin
                  slot0 <= in_data;
               end else begin
                  slot1 <= in_data;
               end
               count <= count + 2'h1;
            end
            2'b01: begin
               slot0 <= slot1;
               count <= count - 2'h1;
            end
            2'b11: begin
               if (count == 2'h1) begin
                  slot0 <= in_data;
               end else begin
                  slot0 <= slot1;
                  slot1 <= in_data;
               end
            end
            default: count <= count;
         endcase
      end
   end
endmodule

// >>> tb/dual_clock_fwft_fifo_ports_test.sv
// Purpose: Self-checking FIFO bench
// Assumes: Presets 64 then 8
// Notes: Port B via host model
`timescale 1ns/1ps
module dual_clock_fwft_fifo_ports_test;
   reg core_clk = 1'b0, rst = 1'b1, port_a_clk = 1'b0;
   reg port_a_select_n = 1'b1, port_a_dir_sel = 1'b1;
   reg port_a_transfer_gate = 1'b0, port_a_mail_sel = 1'b0;
   reg [35:0] port_a_din = 36'h0, b_word = 36'h0;
   reg mode_hi = 1'b1, mode_lo = 1'b0, b_req = 1'b0;
   reg b_dir = 1'b1, b_mail = 1'b0, t;
   reg [3:0] a_phase = 4'h0;
   reg [35:0] rd;
   integer err_total = 0, cmp_count = 0, cycles = 0, n, j;
   wire [35:0] port_a_dout, port_b_dout, port_b_din;
   wire port_a_oe_n, port_b_oe_n, port_b_clk, port_b_select_n, b_done;
   wire port_b_dir_sel, port_b_transfer_gate, port_b_mail_sel;
   wire input_ready, output_ready, almost_empty_n, almost_full_n;
   wire mail_one_flag_n, mail_two_flag_n;
   dual_clock_fwft_fifo_ports dual_clock_fwft_fifo_ports_i (
      .core_clk(core_clk), .rst(rst), .port_a_clk(port_a_clk),
      .port_a_select_n(port_a_select_n), .port_a_dir_sel(port_a_dir_sel),
      .port_a_transfer_gate(port_a_transfer_gate),
      .port_a_mail_sel(port_a_mail_sel), .port_a_din(port_a_din),
      .port_a_dout(port_a_dout), .port_a_oe_n(port_a_oe_n),
      .port_b_clk(port_b_clk), .port_b_select_n(port_b_select_n),
      .port_b_dir_sel(port_b_dir_sel),
      .port_b_transfer_gate(port_b_transfer_gate),
      .port_b_mail_sel(port_b_mail_sel), .port_b_din(port_b_din),
      .port_b_dout(port_b_dout), .port_b_oe_n(port_b_oe_n),
      .offset_mode_sel_hi(mode_hi), .offset_mode_sel_lo(mode_lo),
      .offset_serial_din(1'b0), .offset_serial_load_n(1'b1),
      .input_ready(input_ready), .output_ready(output_ready),
      .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
      .mail_one_flag_n(mail_one_flag_n), .mail_two_flag_n(mail_two_flag_n));
   port_b_host port_b_host_i (
      .core_clk(core_clk), .rst(rst), .req(b_req), .req_dir(b_dir),
      .req_mail(b_mail), .req_word(b_word), .done(b_done),
      .port_b_clk(port_b_clk), .port_b_select_n(port_b_select_n),
      .port_b_dir_sel(port_b_dir_sel),
      .port_b_transfer_gate(port_b_transfer_gate),
      .port_b_mail_sel(port_b_mail_sel), .port_b_din(port_b_din));
   // ==========================================================
   // Clocks
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      a_phase <= (a_phase == 4'h9) ? 4'h0 : a_phase + 4'h1;
      if (a_phase == 4'h4) port_a_clk <= 1'b1;
      if (a_phase == 4'h9) port_a_clk <= 1'b0;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         err_total = err_total + 1;
         wrap_up;
      end
   end
   // ==========================================================
   // Shared tasks
   function [35:0] word(input integer k);
      word = {4'h9, k[31:0]};
   endfunction
   task check(input [35:0] seen, input [35:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
         end
      end
   endtask
   task edges(input b, input integer k);
      begin
         repeat (k) @(posedge (b ? port_b_clk : port_a_clk));
         repeat (4) @(posedge core_clk);
      end
   endtask
   // One port A cycle; ok is input ready
   task a_cycle(input dir, input mail, input [35:0] w, output ok,
         output [35:0] r);
      begin
         @(negedge port_a_clk);
         ok = (input_ready === 1'b1);
         port_a_select_n <= 1'b0;
         port_a_dir_sel <= dir;
         port_a_mail_sel <= mail;
         port_a_transfer_gate <= 1'b1;
         port_a_din <= w;
         @(posedge port_a_clk);
         repeat (4) @(posedge core_clk);
         r = port_a_dout;
         @(negedge port_a_clk);
         port_a_select_n <= 1'b1;
         port_a_transfer_gate <= 1'b0;
         port_a_din <= ~w;
      end
   endtask
   task b_cycle(input dir, input mail, input [35:0] w, output [35:0] r);
      begin
         @(posedge core_clk);
         b_dir <= dir;
         b_mail <= mail;
         b_word <= w;
         b_req <= 1'b1;
         @(negedge port_b_select_n);
         @(posedge port_b_clk);
         repeat (5) @(posedge core_clk);
         r = port_b_dout;
         while (b_done !== 1'b1) @(posedge core_clk);
         b_req <= 1'b0;
      end
   endtask
   // ==========================================================
   // Scenarios
   task t_reset(input hi, input lo);
      begin
         @(posedge core_clk);
         rst <= 1'b1;
         mode_hi <= hi;
         mode_lo <= lo;
         repeat (7) @(negedge port_a_clk);
         rst <= 1'b0;
         edges(1'b0, 1);
         check(input_ready, 1'b0);
         edges(1'b0, 2);
         check(input_ready, 1'b1);
      end
   endtask
   task t_mail;
      begin
         a_cycle(1'b1, 1'b1, 36'hc0ffee123, t, rd);
         check(mail_one_flag_n, 1'b0);
         a_cycle(1'b1, 1'b1, 36'h111111111, t, rd);
         b_cycle(1'b1, 1'b1, 36'h0, rd);
         check(rd, 36'hc0ffee123);
         check(mail_one_flag_n, 1'b1);
         b_cycle(1'b0, 1'b1, 36'h5a5a5a5a5, rd);
         check(mail_two_flag_n, 1'b0);
         a_cycle(1'b0, 1'b1, 36'h0, t, rd);
         check(rd, 36'h5a5a5a5a5);
         check(mail_two_flag_n, 1'b1);
      end
   endtask
   // Fill until refused
   task t_fill(input integer x);
      begin
         n = 0;
         t = 1'b1;
         while (t) begin
            if (n == x + 1 || n == x + 2) begin
               edges(1'b1, 5);
               check(almost_empty_n, n == x + 2);
            end
            if (n == 512 - x || n == 513 - x) begin
               edges(1'b0, 3);
               check(almost_full_n, n == 512 - x);
            end
            a_cycle(1'b1, 1'b0, word(n), t, rd);
            n = n + t;
         end
         check(n, 513);
         check(almost_full_n, 1'b0);
      end
   endtask
   task t_drain;
      begin
         for (j = 0; j < 513; j = j + 1) begin
            while (output_ready !== 1'b1) @(posedge core_clk);
            check(port_b_dout, word(j));
            b_cycle(1'b1, 1'b0, 36'h0, rd);
         end
         edges(1'b1, 4);
         check(output_ready, 1'b0);
         check(port_b_dout, word(512));
         b_cycle(1'b1, 1'b0, 36'h0, rd);
         a_cycle(1'b1, 1'b0, word(700), t, rd);
         edges(1'b1, 1);
         check(output_ready, 1'b0);
         edges(1'b1, 4);
         check(output_ready, 1'b1);
         check(port_b_dout, word(700));
      end
   endtask
   task wrap_up;
      begin
         $display("compares %0d mismatches %0d", cmp_count, err_total);
         if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      t_reset(1'b1, 1'b0);
      t_mail;
      t_fill(64);
      t_drain;
      t_reset(1'b0, 1'b1);
      t_fill(8);
      wrap_up;
   end
endmodule

// >>> tb/fifo_port_checker.sv
// Purpose: Port assertions for the FIFO block
// Assumes: Slow port clocks
// Notes: Flags move only after own port edge
`timescale 1ns/1ps
module fifo_port_checker (
   input wire core_clk,
   input wire rst,
   input wire port_a_clk,
   input wire port_a_select_n,
   input wire port_a_dir_sel,
   input wire port_a_mail_sel,
   input wire port_a_oe_n,
   input wire port_b_clk,
   input wire port_b_select_n,
   input wire port_b_dir_sel,
   input wire port_b_mail_sel,
   input wire [35:0] port_b_dout,
   input wire port_b_oe_n,
   input wire input_ready,
   input wire output_ready,
   input wire almost_empty_n,
   input wire almost_full_n,
   input wire mail_one_flag_n,
   input wire mail_two_flag_n
);
   reg [3:0] a_age, b_age, am_age, bm_age;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   function [3:0] step(input [3:0] v);
      step = (v == 4'hf) ? v : v + 4'h1;
   endfunction
   // ==========================================================
   // Cycles since a port edge or mail select
   always @(posedge core_clk) begin
      a_age <= rst ? 4'hf : ($rose(port_a_clk) ? 4'h0 : step(a_age));
      b_age <= rst ? 4'hf : ($rose(port_b_clk) ? 4'h0 : step(b_age));
      am_age <= rst ? 4'hf : (port_a_mail_sel ? 4'h0 : step(am_age));
      bm_age <= rst ? 4'hf : (port_b_mail_sel ? 4'h0 : step(bm_age));
   end
   // ==========================================================
   // Assertions
   a_reset_levels: assert property (disable iff (1'b0)
      rst && $past(rst) |-> !input_ready && !output_ready && !almost_empty_n
         && almost_full_n && mail_one_flag_n && mail_two_flag_n)
      else $error("flag levels wrong during reset");
   a_oe_a_on: assert property (
      (!port_a_select_n && !port_a_dir_sel) [*5] |-> !port_a_oe_n)
      else $error("port a data not driven");
   a_oe_a_off: assert property (port_a_select_n [*5] |-> port_a_oe_n)
      else $error("port a data driven while deselected");
   a_oe_b_on: assert property (
      (!port_b_select_n && port_b_dir_sel) [*5] |-> !port_b_oe_n)
      else $error("port b data not driven");
   a_out_held: assert property (
      (!output_ready && !port_b_mail_sel) [*6] |-> $stable(port_b_dout))
      else $error("output word moved without output ready");
   a_ir_sync: assert property ($changed(input_ready) |-> a_age <= 4'h6)
      else $error("input ready moved off a port a edge");
   a_af_sync: assert property ($changed(almost_full_n) |-> a_age <= 4'h6)
      else $error("almost full moved off a port a edge");
   a_or_sync: assert property ($changed(output_ready) |-> b_age <= 4'h6)
      else $error("output ready moved off a port b edge");
   a_ae_sync: assert property ($changed(almost_empty_n) |-> b_age <= 4'h6)
      else $error("almost empty moved off a port b edge");
   a_mail_one: assert property ($fell(mail_one_flag_n) |-> am_age <= 4'h6)
      else $error("mail one flag set without port a mailbox write");
   a_mail_two: assert property ($fell(mail_two_flag_n) |-> bm_age <= 4'h6)
      else $error("mail two flag set without port b mailbox write");
endmodule

bind dual_clock_fwft_fifo_ports fifo_port_checker fifo_port_checker_i (.*);

// >>> tb/port_b_host.sv
// Purpose: Port B host model
// Assumes: One request at a time
// Notes: Drives on a falling port clock
`timescale 1ns/1ps
module port_b_host (
   input wire core_clk,
   input wire rst,
   input wire req,
   input wire req_dir,
   input wire req_mail,
   input wire [35:0] req_word,
   output reg done = 1'b0,
   output reg port_b_clk = 1'b0,
   output reg port_b_select_n = 1'b1,
   output reg port_b_dir_sel = 1'b1,
   output reg port_b_transfer_gate = 1'b0,
   output reg port_b_mail_sel = 1'b0,
   output reg [35:0] port_b_din = 36'h0
);
   reg [3:0] phase = 4'h0;
   reg busy = 1'b0;
   // Free port clock, 12 core cycles
   always @(posedge core_clk) begin
      phase <= (phase == 4'hb) ? 4'h0 : phase + 4'h1;
      if (phase == 4'h5) port_b_clk <= 1'b1;
      if (phase == 4'hb) port_b_clk <= 1'b0;
   end
   // Drive, then release a period later
   always @(posedge core_clk) begin
      done <= 1'b0;
      if (rst) begin
         busy <= 1'b0;
         port_b_select_n <= 1'b1;
         port_b_transfer_gate <= 1'b0;
      end else if (phase == 4'hb && busy) begin
         busy <= 1'b0;
         done <= 1'b1;
         port_b_select_n <= 1'b1;
         port_b_transfer_gate <= 1'b0;
         port_b_mail_sel <= 1'b0;
         port_b_din <= ~port_b_din;
      end else if (phase == 4'hb && req) begin
         busy <= 1'b1;
         port_b_select_n <= 1'b0;
         port_b_transfer_gate <= 1'b1;
         port_b_dir_sel <= req_dir;
         port_b_mail_sel <= req_mail;
         port_b_din <= req_word;
      end
   end
endmodule
